// [udsb_core.sv]
// UART channel DMA request, sleep control, RX idle, break and baud generator
//
// Behaviour
// - With FIFO enable bit 0 set, FIFO control bit 3 selects single-character or block DMA request signalling.
// - Block mode: transmit request rises once free space reaches transmit trigger.
// - Block mode: transmit request falls only when the TX FIFO is full.
// - Block mode: receive request rises at receive trigger or on receive timeout.
// - Block mode: receive request falls when RX FIFO empties or FIFO error sets.
// - Sleep allowed only with enhanced-functions bit and sleep enable bit both set.
// - Sleep needs idle input, empty transmitter, no pending interrupt besides tx-empty/timeout.
// - Never sleep while the RX FIFO holds a character.
// - Asleep: core clock enable and baud clock both stopped.
// - Wake on serial input edge, modem input change or TX FIFO write.
// - RX idle after input high for four times word length plus twelve bits.
// - Serial input is sampled mid-bit for idle evaluation.
// - Break control bit forces the serial output low.
// - Baud divisor is 16 bits, any value from 1 to 65535.
// - Modem control bit 7 inserts a divide-by-4 prescaler before the divisor.
// - Prescaler divides by one after reset.
// - Baud tick is the 16x oversampling clock.
// - Divisor low byte is bits 7..0, high byte bits 15..8.
// - Zero divisor produces no baud tick.
// - One baud tick times both transmitter and receiver.
`timescale 1ns/1ps
`include "udsb_params.svh"

module udsb_core (
  // Clock and reset
  input  wire logic                     I_CORE_CLK,
  input  wire logic                     I_RST,
  // Register port
  input  wire logic [`UDSB_ADDR_W-1:0]  I_ADDR,
  input  wire logic [7:0]               I_WDATA,
  input  wire logic                     I_WR,
  input  wire logic                     I_RD,
  output logic      [7:0]               O_RDATA,
  // Channel status
  input  wire udsb_pkg::udsb_fifo_t     I_FIFO,
  input  wire udsb_pkg::udsb_evt_t      I_EVT,
  // Serial and modem pins
  input  wire logic                     I_RX_PIN,
  input  wire logic [3:0]               I_MODEM_PINS,
  input  wire logic                     I_TX_SER,
  output logic                          O_TX_PIN,
  // DMA requests
  output logic                          O_TX_DMA_REQ,
  output logic                          O_RX_DMA_REQ,
  // Clocking and power
  output logic                          O_BAUD_TICK,
  output logic                          O_CLK_EN,
  output logic                          O_RX_IDLE
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]            fifo_control_reg;
  logic [7:0]            interrupt_enable_reg;
  logic [7:0]            line_control_reg;
  logic [7:0]            modem_control_reg;
  logic [7:0]            divisor_low_byte_reg;
  logic [7:0]            divisor_high_byte_reg;
  logic [7:0]            enhanced_feature_reg;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;
  logic [7:0]            status_word;
  logic [15:0]           divisor;

  udsb_pkg::udsb_sleep_t sleep_reg;
  logic                  asleep;
  logic                  sleep_permit;
  logic                  sleep_ready;
  logic                  wake;

  logic [4:0]            sync1_reg;
  logic [4:0]            sync2_reg;
  logic [4:0]            sync3_reg;
  logic                  rx_s;
  logic                  rx_edge;
  logic                  modem_edge;

  logic [1:0]            presc_cnt_reg;
  logic [15:0]           div_cnt_reg;
  logic                  baud_tick_reg;
  logic                  presc_stroke;

  logic [3:0]            sub_cnt_reg;
  logic [5:0]            idle_bits_reg;
  logic                  rx_idle_reg;
  logic [5:0]            idle_thresh;

  logic                  tx_req_reg;
  logic                  rx_req_reg;
  logic                  tx_pin_reg;
  logic                  block_mode;
  logic [6:0]            tx_free;
  logic                  tx_full;
  logic                  rx_empty;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      fifo_control_reg      <= `UDSB_RST_ZERO;
      interrupt_enable_reg  <= `UDSB_RST_ZERO;
      line_control_reg      <= `UDSB_RST_LINE;
      modem_control_reg     <= `UDSB_RST_ZERO;
      divisor_low_byte_reg  <= `UDSB_RST_ZERO;
      divisor_high_byte_reg <= `UDSB_RST_ZERO;
      enhanced_feature_reg  <= `UDSB_RST_ZERO;
    end else if (I_WR) begin
      case (I_ADDR)
        `UDSB_OFF_FIFO: begin
          fifo_control_reg <= I_WDATA;
        end
        `UDSB_OFF_INTEN: begin
          interrupt_enable_reg <= I_WDATA;
        end
        `UDSB_OFF_LINE: begin
          line_control_reg <= I_WDATA;
        end
        `UDSB_OFF_MODEM: begin
          modem_control_reg <= I_WDATA;
        end
        // Taken even while asleep; the count only reloads after wake
        `UDSB_OFF_DLL: begin
          divisor_low_byte_reg <= I_WDATA;
        end
        `UDSB_OFF_DIVHI: begin
          divisor_high_byte_reg <= I_WDATA;
        end
        `UDSB_OFF_ENH: begin
          enhanced_feature_reg <= I_WDATA;
        end
        default: begin
        end
      endcase
    end
  end

  assign divisor = {divisor_high_byte_reg, divisor_low_byte_reg};

  // ****************************************
  // Register reads
  // ****************************************
  assign status_word = {3'h0, (divisor != 16'h0000), rx_req_reg, tx_req_reg,
                        rx_idle_reg, asleep};

  always_comb begin
    rdata_next = `UDSB_RST_ZERO;
    case (I_ADDR)
      `UDSB_OFF_FIFO: begin
        rdata_next = fifo_control_reg;
      end
      `UDSB_OFF_INTEN: begin
        rdata_next = interrupt_enable_reg;
      end
      `UDSB_OFF_LINE: begin
        rdata_next = line_control_reg;
      end
      `UDSB_OFF_MODEM: begin
        rdata_next = modem_control_reg;
      end
      `UDSB_OFF_DLL: begin
        rdata_next = divisor_low_byte_reg;
      end
      `UDSB_OFF_DIVHI: begin
        rdata_next = divisor_high_byte_reg;
      end
      `UDSB_OFF_ENH: begin
        rdata_next = enhanced_feature_reg;
      end
      `UDSB_OFF_STAT: begin
        rdata_next = status_word;
      end
      default: begin
        rdata_next = `UDSB_RST_ZERO;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= `UDSB_RST_ZERO;
    end else if (I_RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `UDSB_RST_ZERO;
    end
  end

  assign O_RDATA = rdata_reg;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit 4 is the serial input, bits 3..0 the modem inputs
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync1_reg <= 5'h1F;
      sync2_reg <= 5'h1F;
      sync3_reg <= 5'h1F;
    end else begin
      sync1_reg <= {I_RX_PIN, I_MODEM_PINS};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rx_s       = sync2_reg[4];
  assign rx_edge    = sync2_reg[4] ^ sync3_reg[4];
  assign modem_edge = |(sync2_reg[3:0] ^ sync3_reg[3:0]);

  // ****************************************
  // Prescaler and baud generator
  // ****************************************
  assign presc_stroke = !modem_control_reg[`UDSB_PRESC_BIT]
                        || (presc_cnt_reg == `UDSB_PRESC_LAST);

  // Stopped asleep and with a zero divisor; counts restart from zero
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      presc_cnt_reg <= 2'h0;
      div_cnt_reg   <= 16'h0000;
      baud_tick_reg <= 1'b0;
    end else if (asleep || (divisor == 16'h0000)) begin
      presc_cnt_reg <= 2'h0;
      div_cnt_reg   <= 16'h0000;
      baud_tick_reg <= 1'b0;
    end else begin
      presc_cnt_reg <= modem_control_reg[`UDSB_PRESC_BIT] ? presc_cnt_reg + 2'h1 : 2'h0;
      if (presc_stroke) begin
        if (div_cnt_reg >= divisor - 16'h0001) begin
          div_cnt_reg   <= 16'h0000;
          baud_tick_reg <= 1'b1;
        end else begin
          div_cnt_reg   <= div_cnt_reg + 16'h0001;
          baud_tick_reg <= 1'b0;
        end
      end else begin
        baud_tick_reg <= 1'b0;
      end
    end
  end

  // Single tick shared by transmitter and receiver
  assign O_BAUD_TICK = baud_tick_reg;

  // ****************************************
  // RX idle detection
  // ****************************************
  assign idle_thresh = 6'((`UDSB_WORD_BASE
                       + {4'h0, line_control_reg[`UDSB_WLEN_HI:`UDSB_WLEN_LO]})
                       << `UDSB_IDLE_SHIFT) + `UDSB_IDLE_EXTRA;

  // An input edge clears idle at once so a wake cannot re-enter sleep on stale idle
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sub_cnt_reg   <= 4'h0;
      idle_bits_reg <= 6'h00;
      rx_idle_reg   <= 1'b0;
    end else if (rx_edge) begin
      sub_cnt_reg   <= 4'h0;
      idle_bits_reg <= 6'h00;
      rx_idle_reg   <= 1'b0;
    end else if (baud_tick_reg) begin
      sub_cnt_reg <= sub_cnt_reg + 4'h1;
      if (sub_cnt_reg == `UDSB_MID_SAMPLE) begin
        if (!rx_s) begin
          idle_bits_reg <= 6'h00;
          rx_idle_reg   <= 1'b0;
        end else if (idle_bits_reg < idle_thresh) begin
          idle_bits_reg <= idle_bits_reg + 6'h01;
          rx_idle_reg   <= (idle_bits_reg + 6'h01) >= idle_thresh;
        end
      end
    end
  end

  assign O_RX_IDLE = rx_idle_reg;

  // ****************************************
  // Sleep control
  // ****************************************
  assign asleep       = (sleep_reg == udsb_pkg::UDSB_ASLEEP);
  assign sleep_permit = enhanced_feature_reg[`UDSB_ENH_FUNC_BIT]
                        && interrupt_enable_reg[`UDSB_SLEEP_EN_BIT];
  assign sleep_ready  = sleep_permit && rx_idle_reg
                        && (I_FIFO.tx_level == 7'h00) && I_EVT.tx_shift_empty
                        && !I_EVT.int_pend_other
                        && (I_FIFO.rx_level == 7'h00);
  assign wake         = rx_edge || modem_edge || I_EVT.tx_fifo_wr;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sleep_reg <= udsb_pkg::UDSB_AWAKE;
    end else begin
      case (sleep_reg)
        udsb_pkg::UDSB_AWAKE: begin
          if (sleep_ready && !wake) begin
            sleep_reg <= udsb_pkg::UDSB_ASLEEP;
          end
        end
        udsb_pkg::UDSB_ASLEEP: begin
          if (wake || !sleep_permit) begin
            sleep_reg <= udsb_pkg::UDSB_AWAKE;
          end
        end
        default: begin
          sleep_reg <= udsb_pkg::UDSB_AWAKE;
        end
      endcase
    end
  end

  // Core clock gate enable for the rest of the channel
  assign O_CLK_EN = !asleep;

  // ****************************************
  // DMA requests
  // ****************************************
  assign block_mode = fifo_control_reg[`UDSB_DMA_MODE_BIT]
                      && fifo_control_reg[`UDSB_FIFO_EN_BIT];
  assign tx_free    = `UDSB_FIFO_DEPTH - I_FIFO.tx_level;
  assign tx_full    = (I_FIFO.tx_level == `UDSB_FIFO_DEPTH);
  assign rx_empty   = (I_FIFO.rx_level == 7'h00);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_req_reg <= 1'b1;
    end else if (!block_mode) begin
      tx_req_reg <= (I_FIFO.tx_level == 7'h00);
    end else if (tx_full) begin
      tx_req_reg <= 1'b0;
    end else if (tx_free >= I_FIFO.tx_trig) begin
      tx_req_reg <= 1'b1;
    end
  end

  // Clear wins over set: an error must stop a running block
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_req_reg <= 1'b0;
    end else if (!block_mode) begin
      rx_req_reg <= !rx_empty;
    end else if (rx_empty || I_EVT.fifo_err) begin
      rx_req_reg <= 1'b0;
    end else if ((I_FIFO.rx_level >= I_FIFO.rx_trig) || I_EVT.rx_timeout) begin
      rx_req_reg <= 1'b1;
    end
  end

  assign O_TX_DMA_REQ = tx_req_reg;
  assign O_RX_DMA_REQ = rx_req_reg;

  // ****************************************
  // Break
  // ****************************************
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_pin_reg <= 1'b1;
    end else begin
      tx_pin_reg <= line_control_reg[`UDSB_BREAK_BIT] ? 1'b0 : I_TX_SER;
    end
  end

  assign O_TX_PIN = tx_pin_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  property p_break_low;
    line_control_reg[`UDSB_BREAK_BIT] |=> !O_TX_PIN;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not driving low");

  property p_tx_full_clear;
    block_mode && tx_full |=> !O_TX_DMA_REQ;
  endproperty
  a_tx_full_clear: assert property (p_tx_full_clear) else $error("tx request on full");

  property p_tx_set;
    block_mode && !tx_full && (tx_free >= I_FIFO.tx_trig) |=> O_TX_DMA_REQ;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx request missing");

  property p_rx_clear;
    block_mode && (rx_empty || I_EVT.fifo_err) |=> !O_RX_DMA_REQ;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx request not cleared");

  property p_rx_set;
    block_mode && !rx_empty && !I_EVT.fifo_err
      && ((I_FIFO.rx_level >= I_FIFO.rx_trig) || I_EVT.rx_timeout) |=> O_RX_DMA_REQ;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx request missing");

  property p_single_mode;
    !block_mode |=> (O_TX_DMA_REQ == ($past(I_FIFO.tx_level) == 7'h00))
                    && (O_RX_DMA_REQ == !$past(rx_empty));
  endproperty
  a_single_mode: assert property (p_single_mode) else $error("single mode request wrong");

  property p_no_sleep_rx;
    !asleep && !rx_empty |=> !asleep;
  endproperty
  a_no_sleep_rx: assert property (p_no_sleep_rx) else $error("slept with rx data");

  property p_sleep_permit;
    $rose(asleep) |-> $past(sleep_permit) && $past(I_EVT.tx_shift_empty);
  endproperty
  a_sleep_permit: assert property (p_sleep_permit) else $error("sleep not permitted");

  property p_gated;
    asleep |-> !O_CLK_EN ##1 !O_BAUD_TICK;
  endproperty
  a_gated: assert property (p_gated) else $error("clock running asleep");

  property p_wake;
    asleep && I_EVT.tx_fifo_wr |=> !asleep ##1 O_CLK_EN;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on write");

  property p_zero_div;
    (divisor == 16'h0000) |=> !O_BAUD_TICK;
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("tick with zero divisor");

  property p_tick_gap;
    O_BAUD_TICK && (divisor > 16'h0001) && $stable(divisor) |=> !O_BAUD_TICK;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick faster than divisor");

  property p_presc_gap;
    O_BAUD_TICK && modem_control_reg[`UDSB_PRESC_BIT] |=> !O_BAUD_TICK [*3];
  endproperty
  a_presc_gap: assert property (p_presc_gap) else $error("prescaler not dividing");

  property p_idle_rise;
    $rose(O_RX_IDLE) |-> $past(rx_s) && ($past(sub_cnt_reg) == `UDSB_MID_SAMPLE);
  endproperty
  a_idle_rise: assert property (p_idle_rise) else $error("idle not from mid sample");

  c_sleep_entry: cover property ($rose(asleep));
  c_wake_rx:     cover property (asleep && rx_edge ##1 !asleep);
  c_tx_block:    cover property (block_mode && $rose(O_TX_DMA_REQ));
  c_rx_timeout:  cover property (block_mode && I_EVT.rx_timeout ##1 $rose(O_RX_DMA_REQ));

endmodule

// [udsb_params.svh]
// Constants for the UART DMA, sleep and baud generator block
`ifndef UDSB_PARAMS_SVH
`define UDSB_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define UDSB_ADDR_W        3
`define UDSB_OFF_FIFO      3'h0
`define UDSB_OFF_INTEN     3'h1
`define UDSB_OFF_LINE      3'h2
`define UDSB_OFF_MODEM     3'h3
`define UDSB_OFF_DLL       3'h4
`define UDSB_OFF_DIVHI     3'h5
`define UDSB_OFF_ENH       3'h6
`define UDSB_OFF_STAT      3'h7

// ****************************************
// Field positions and reset values
// ****************************************
`define UDSB_FIFO_EN_BIT   0
`define UDSB_DMA_MODE_BIT  3
`define UDSB_SLEEP_EN_BIT  4
`define UDSB_ENH_FUNC_BIT  4
`define UDSB_BREAK_BIT     6
`define UDSB_PRESC_BIT     7
`define UDSB_WLEN_HI       1
`define UDSB_WLEN_LO       0
`define UDSB_RST_ZERO      8'h00
`define UDSB_RST_LINE      8'h1D

// ****************************************
// Counts
// ****************************************
`define UDSB_FIFO_DEPTH    7'h40
`define UDSB_PRESC_LAST    2'h3
`define UDSB_MID_SAMPLE    4'h7
`define UDSB_WORD_BASE     6'h05
`define UDSB_IDLE_SHIFT    2
`define UDSB_IDLE_EXTRA    6'h0C

`endif

// [udsb_pkg.sv]
// Types shared by the UART DMA, sleep and baud generator block
package udsb_pkg;

  // FIFO levels and trigger levels from the rest of the channel
  typedef struct packed {
    logic [6:0] tx_level;
    logic [6:0] tx_trig;
    logic [6:0] rx_level;
    logic [6:0] rx_trig;
  } udsb_fifo_t;

  // Channel events that gate sleep and the receive request
  typedef struct packed {
    logic tx_shift_empty;
    logic int_pend_other;
    logic rx_timeout;
    logic fifo_err;
    logic tx_fifo_wr;
  } udsb_evt_t;

  typedef enum logic {
    UDSB_AWAKE,
    UDSB_ASLEEP
  } udsb_sleep_t;

endpackage

// [udsb_dma_model.sv]
// DMA controller model that services the channel's transfer requests
`timescale 1ns/1ps

module udsb_dma_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Requests from the channel
  input  wire logic       i_tx_req,
  input  wire logic       i_rx_req,
  // Bench control
  input  wire logic       i_go,
  input  wire logic       i_slow,
  input  wire logic       i_load,
  input  wire logic [6:0] i_tx_init,
  input  wire logic [6:0] i_rx_init,
  // FIFO levels and write pulse seen by the channel
  output logic      [6:0] o_tx_level,
  output logic      [6:0] o_rx_level,
  output logic            o_tx_wr
);
  logic [1:0] pace_reg;
  logic       act;
  logic       put;

  // Slow mode serves one cycle in four, as a busy controller would
  assign act = i_go && (!i_slow || pace_reg == 2'h3);
  // Requests are obeyed as seen; the full guard stands in for the FIFO itself
  assign put = act && i_tx_req && o_tx_level != 7'h40;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pace_reg <= 2'h0;
    end else begin
      pace_reg <= pace_reg + 2'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_level <= 7'h00;
      o_rx_level <= 7'h00;
      o_tx_wr    <= 1'b0;
    end else if (i_load) begin
      o_tx_level <= i_tx_init;
      o_rx_level <= i_rx_init;
      o_tx_wr    <= 1'b0;
    end else begin
      o_tx_wr <= put;
      if (put) begin
        o_tx_level <= o_tx_level + 7'h01;
      end
      if (act && i_rx_req && o_rx_level != 7'h00) begin
        o_rx_level <= o_rx_level - 7'h01;
      end
    end
  end
endmodule

// [udsb_core_tb_top.sv]
// Self-checking bench for the DMA, sleep, idle, break and baud block
`timescale 1ns/1ps
`include "udsb_params.svh"

module udsb_core_tb_top;
  logic       clk, rst, wr, rd, rx_pin, tx_ser, tse, ipo, rto, ferr, go, slow, load;
  logic       tx_pin, txq, rxq, tick, clk_en, idle, m_wr;
  logic [2:0] addr;
  logic [3:0] modem;
  logic [6:0] tx_trig, rx_trig, tx_init, rx_init, m_tx, m_rx;
  logic [7:0] wdata, rdata, rv;
  int         errors, checked;
  udsb_pkg::udsb_fifo_t fifo;
  udsb_pkg::udsb_evt_t  evt;

  assign fifo = {m_tx, tx_trig, m_rx, rx_trig};
  assign evt  = {tse, ipo, rto, ferr, m_wr};

  udsb_core uut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_FIFO(fifo), .I_EVT(evt), .I_RX_PIN(rx_pin), .I_MODEM_PINS(modem),
    .I_TX_SER(tx_ser), .O_TX_PIN(tx_pin), .O_TX_DMA_REQ(txq), .O_RX_DMA_REQ(rxq),
    .O_BAUD_TICK(tick), .O_CLK_EN(clk_en), .O_RX_IDLE(idle));

  udsb_dma_model dma (
    .i_clk(clk), .i_rst(rst), .i_tx_req(txq), .i_rx_req(rxq), .i_go(go), .i_slow(slow),
    .i_load(load), .i_tx_init(tx_init), .i_rx_init(rx_init), .o_tx_level(m_tx),
    .o_rx_level(m_rx), .o_tx_wr(m_wr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Loaded at one edge, seen by the design's registers one edge on
  task automatic setlv(logic [6:0] t, logic [6:0] r);
    @(posedge clk);
    tx_init <= t;
    rx_init <= r;
    load    <= 1'b1;
    @(posedge clk);
    load    <= 1'b0;
    cyc(2);
  endtask

  function automatic logic pick(int s);
    case (s)
      0: pick = clk_en;
      1: pick = tick;
      2: pick = txq;
      3: pick = rxq;
      default: pick = idle;
    endcase
  endfunction

  task automatic waitv(string n, int s, logic v, int lim);
    int k;
    for (k = 0; k < lim && pick(s) !== v; k++) begin
      cyc(1);
    end
    chk(n, pick(s), v);
    if (pick(s) !== v) begin
      final_report();
    end
  endtask

  task automatic quiet(string n, int len);
    int c;
    c = 0;
    repeat (len) begin
      cyc(1);
      if (tick !== 1'b0) begin
        c++;
      end
    end
    chk(n, 16'(c), 16'h0000);
  endtask

  // Second interval is measured, the first may straddle a reprogram
  task automatic gap(int exp);
    int n;
    waitv("tick", 1, 1'b1, 2000);
    cyc(1);
    waitv("tick", 1, 1'b1, 2000);
    cyc(1);
    n = 1;
    while (tick !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk("baud gap", 16'(n), 16'(exp));
    if (tick !== 1'b1) begin
      final_report();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    tx_ser <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("tx pin", tx_pin, 1'b1);
    chk("clk en", clk_en, 1'b1);
    chk("rx req", rxq, 1'b0);
    chk("idle", idle, 1'b0);
    rd_reg(`UDSB_OFF_MODEM, rv);
    chk("modem ctl", rv, `UDSB_RST_ZERO);
    rd_reg(`UDSB_OFF_LINE, rv);
    chk("line ctl", rv, `UDSB_RST_LINE);
    quiet("no tick at reset", 300);
    $display("t_reset done");
  endtask

  task automatic t_baud();
    wr_reg(`UDSB_OFF_DLL, 8'h03);
    wr_reg(`UDSB_OFF_DIVHI, 8'h00);
    gap(3);
    wr_reg(`UDSB_OFF_MODEM, 8'h80);
    gap(12);
    wr_reg(`UDSB_OFF_MODEM, 8'h00);
    wr_reg(`UDSB_OFF_DLL, 8'h00);
    wr_reg(`UDSB_OFF_DIVHI, 8'h01);
    gap(256);
    wr_reg(`UDSB_OFF_DIVHI, 8'h00);
    quiet("no tick zero divisor", 300);
    // 40 MHz over 1 x 16 x 2.5 Mbit/s gives a divisor of one
    wr_reg(`UDSB_OFF_DLL, 8'h01);
    gap(1);
    $display("t_baud done");
  endtask

  task automatic t_idle();
    int n, b;
    for (int wl = 0; wl < 4; wl++) begin
      b = 4 * (wl + 5) + 12;
      wr_reg(`UDSB_OFF_LINE, 8'(wl));
      @(posedge clk);
      rx_pin <= 1'b0;
      cyc(40);
      chk("idle low", idle, 1'b0);
      @(posedge clk);
      rx_pin <= 1'b1;
      n = 0;
      while (idle !== 1'b1 && n < 1200) begin
        cyc(1);
        n++;
      end
      chk("idle time", 16'(n >= (b - 1) * 16 && n <= b * 16 + 6), 16'h0001);
      if (idle !== 1'b1) begin
        final_report();
      end
    end
    $display("t_idle done");
  endtask

  task automatic t_sleep();
    @(posedge clk);
    tse <= 1'b1;
    ipo <= 1'b1;
    setlv(7'h00, 7'h00);
    wr_reg(`UDSB_OFF_INTEN, 8'h10);
    cyc(4);
    chk("awake enh off", clk_en, 1'b1);
    wr_reg(`UDSB_OFF_ENH, 8'h10);
    cyc(4);
    chk("awake int pend", clk_en, 1'b1);
    setlv(7'h00, 7'h01);
    @(posedge clk);
    ipo <= 1'b0;
    cyc(4);
    chk("awake rx data", clk_en, 1'b1);
    setlv(7'h00, 7'h00);
    waitv("asleep", 0, 1'b0, 8);
    quiet("no tick asleep", 50);
    rd_reg(`UDSB_OFF_STAT, rv);
    chk("status asleep", rv, 8'h17);
    @(posedge clk);
    modem <= 4'h2;
    waitv("wake modem", 0, 1'b1, 8);
    waitv("asleep", 0, 1'b0, 800);
    @(posedge clk);
    go <= 1'b1;
    waitv("wake tx write", 0, 1'b1, 8);
    @(posedge clk);
    go <= 1'b0;
    setlv(7'h00, 7'h00);
    waitv("asleep", 0, 1'b0, 800);
    @(posedge clk);
    rx_pin <= 1'b0;
    waitv("wake rx edge", 0, 1'b1, 8);
    @(posedge clk);
    rx_pin <= 1'b1;
    // Sleep enable is cleared before any later divisor write
    wr_reg(`UDSB_OFF_INTEN, 8'h00);
    $display("t_sleep done");
  endtask

  task automatic t_dma();
    wr_reg(`UDSB_OFF_FIFO, 8'h01);
    setlv(7'h00, 7'h00);
    chk("tx mode0 empty", txq, 1'b1);
    chk("rx mode0 empty", rxq, 1'b0);
    setlv(7'h05, 7'h03);
    chk("tx mode0 data", txq, 1'b0);
    chk("rx mode0 data", rxq, 1'b1);
    wr_reg(`UDSB_OFF_FIFO, 8'h09);
    @(posedge clk);
    tx_trig <= 7'h10;
    rx_trig <= 7'h08;
    setlv(7'h40, 7'h00);
    chk("tx full", txq, 1'b0);
    setlv(7'h31, 7'h07);
    chk("tx below trig", txq, 1'b0);
    chk("rx below trig", rxq, 1'b0);
    setlv(7'h30, 7'h08);
    chk("tx at trig", txq, 1'b1);
    chk("rx at trig", rxq, 1'b1);
    setlv(7'h3C, 7'h04);
    chk("tx held", txq, 1'b1);
    chk("rx held", rxq, 1'b1);
    @(posedge clk);
    go <= 1'b1;
    waitv("tx drop fast", 2, 1'b0, 20);
    chk("fill level", 16'(m_tx), 16'h0040);
    waitv("rx drop fast", 3, 1'b0, 20);
    @(posedge clk);
    go   <= 1'b0;
    slow <= 1'b1;
    setlv(7'h28, 7'h09);
    @(posedge clk);
    go <= 1'b1;
    waitv("rx drop slow", 3, 1'b0, 200);
    chk("drain level", 16'(m_rx), 16'h0000);
    waitv("tx drop slow", 2, 1'b0, 200);
    @(posedge clk);
    go <= 1'b0;
    setlv(7'h00, 7'h02);
    @(posedge clk);
    rto <= 1'b1;
    @(posedge clk);
    rto <= 1'b0;
    cyc(2);
    chk("rx timeout", rxq, 1'b1);
    @(posedge clk);
    ferr <= 1'b1;
    cyc(2);
    chk("rx fifo error", rxq, 1'b0);
    @(posedge clk);
    ferr <= 1'b0;
    $display("t_dma done");
  endtask

  task automatic t_break();
    wr_reg(`UDSB_OFF_LINE, 8'h43);
    cyc(2);
    chk("break low", tx_pin, 1'b0);
    cyc(20);
    chk("break held", tx_pin, 1'b0);
    wr_reg(`UDSB_OFF_LINE, 8'h03);
    cyc(2);
    chk("line high", tx_pin, 1'b1);
    @(posedge clk);
    tx_ser <= 1'b0;
    cyc(2);
    chk("line follows", tx_pin, 1'b0);
    $display("t_break done");
  endtask

  initial begin
    {rst, wr, rd, tse, ipo, rto, ferr, go, slow, load} = 10'h200;
    {addr, wdata, modem, tx_trig, rx_trig, tx_init, rx_init} = 43'h0;
    {rx_pin, tx_ser} = 2'h3;
    errors  = 0;
    checked = 0;
    t_reset();
    t_baud();
    t_idle();
    t_sleep();
    t_dma();
    t_break();
    wr_reg(`UDSB_OFF_MODEM, 8'h80);
    t_reset();
    final_report();
  end
endmodule
